/* File: bstap_pkg.sv */
// constants, types and state codes of the boundary-scan test port
//
// Behaviour
// R1 - four-bit instruction register selects test and data register
// R2 - instruction codes shift in least significant bit first
// R3 - bypass register is exactly one bit wide
// R4 - in Shift-DR with bypass, tdi enters bypass, old bit leaves on tdo
// R5 - boundary register is one 297-bit shift chain over pad cells
// R6 - tdi enters the boundary register at its lsb
// R7 - boundary register msb drives tdo while it shifts
// R8 - tdi and tms are sampled on rising tck
// R9 - tdo changes only on falling tck
// R10 - all port logic runs on tck alone
// R11 - standard sixteen-state controller steered by tms
// R12 - trst low forces Test-Logic-Reset
// R13 - five rising tck edges with tms high reach Test-Logic-Reset
// R14 - controller stays in Test-Logic-Reset while tms stays high
// R15 - identification, usercode, intest and runbist are not decoded
// R16 - held instruction picks the data register between tdi and tdo
// R17 - in normal operation boundary cells are transparent
// R18 - excluded analog and control pins are left untouched
// R19 - Capture-IR loads 0001 into the instruction shift stage
// R20 - Test-Logic-Reset selects default register, clears msb, outputs off
// R21 - parallel latches update only in Update-DR on rising tck
// R22 - transitions follow standard dr and ir columns with pause and exits
// R23 - standard extest, sample/preload, bypass codes; others select bypass
// R24 - tdo is high impedance except in Shift-DR and Shift-IR
package bstap_pkg;

    // ------------------------------------------------------------
    // widths and codes
    // ------------------------------------------------------------
    localparam int IR_W = 4;
    localparam int BSR_LEN = 297;
    localparam int BSR_IN_CELLS = 148;
    localparam logic [IR_W-1:0] IR_EXTEST = 4'h0;
    localparam logic [IR_W-1:0] IR_SAMPLE = 4'h1;
    localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
    localparam logic [IR_W-1:0] IR_RESET = 4'hf;
    localparam logic BYP_RESET = 1'b0;

    // ------------------------------------------------------------
    // controller states
    // ------------------------------------------------------------
    typedef enum logic [15:0] {
        ST_RESET = 16'h0001,
        ST_IDLE = 16'h0002,
        ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008,
        ST_SH_DR = 16'h0010,
        ST_EX1_DR = 16'h0020,
        ST_PAU_DR = 16'h0040,
        ST_EX2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100,
        ST_SEL_IR = 16'h0200,
        ST_CAP_IR = 16'h0400,
        ST_SH_IR = 16'h0800,
        ST_EX1_IR = 16'h1000,
        ST_PAU_IR = 16'h2000,
        ST_EX2_IR = 16'h4000,
        ST_UPD_IR = 16'h8000
    } bstap_state_e;

    // serial pins sampled together on rising tck
    typedef struct packed {
        logic tms;
        logic tdi;
    } bstap_pins_s;

endpackage

/* File: bstap_top.sv */
// boundary-scan test access port with pad cells and core-side status
module bstap_top
    import bstap_pkg::*;
#(
    parameter int LEN = BSR_LEN,
    parameter int NIN = BSR_IN_CELLS
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic trst_n,
    input wire bstap_pins_s jtag_in,
    output logic tdo_o,
    output logic tdo_oe,
    input wire logic [NIN-1:0] pad_in,
    output logic [NIN-1:0] core_in,
    input wire logic [LEN-NIN-2:0] core_out,
    input wire logic core_oe,
    output logic [LEN-NIN-2:0] pad_out,
    output logic pad_oe,
    output logic test_mode_q
);

    localparam int NOUT = LEN - NIN - 1;

    // ------------------------------------------------------------
    // controller, tck domain only
    // ------------------------------------------------------------
    bstap_state_e state_q;
    bstap_state_e state_d;

    always_comb begin
        state_d = ST_RESET;
        unique case (state_q)
            ST_RESET: begin
                if (jtag_in.tms) begin
                    state_d = ST_RESET; // R14
                end else begin
                    state_d = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (jtag_in.tms) begin
                    state_d = ST_SEL_DR; // R22
                end else begin
                    state_d = ST_IDLE;
                end
            end
            ST_SEL_DR: begin
                if (jtag_in.tms) begin
                    state_d = ST_SEL_IR;
                end else begin
                    state_d = ST_CAP_DR;
                end
            end
            ST_CAP_DR: begin
                if (jtag_in.tms) begin
                    state_d = ST_EX1_DR;
                end else begin
                    state_d = ST_SH_DR;
                end
            end
            ST_SH_DR: begin
                if (jtag_in.tms) begin
                    state_d = ST_EX1_DR;
                end else begin
                    state_d = ST_SH_DR;
                end
            end
            ST_EX1_DR: begin
                if (jtag_in.tms) begin
                    state_d = ST_UPD_DR;
                end else begin
                    state_d = ST_PAU_DR;
                end
            end
            ST_PAU_DR: begin
                if (jtag_in.tms) begin
                    state_d = ST_EX2_DR;
                end else begin
                    state_d = ST_PAU_DR;
                end
            end
            ST_EX2_DR: begin
                if (jtag_in.tms) begin
                    state_d = ST_UPD_DR;
                end else begin
                    state_d = ST_SH_DR;
                end
            end
            ST_UPD_DR: begin
                if (jtag_in.tms) begin
                    state_d = ST_SEL_DR;
                end else begin
                    state_d = ST_IDLE;
                end
            end
            ST_SEL_IR: begin
                if (jtag_in.tms) begin
                    state_d = ST_RESET; // R13
                end else begin
                    state_d = ST_CAP_IR;
                end
            end
            ST_CAP_IR: begin
                if (jtag_in.tms) begin
                    state_d = ST_EX1_IR;
                end else begin
                    state_d = ST_SH_IR;
                end
            end
            ST_SH_IR: begin
                if (jtag_in.tms) begin
                    state_d = ST_EX1_IR;
                end else begin
                    state_d = ST_SH_IR;
                end
            end
            ST_EX1_IR: begin
                if (jtag_in.tms) begin
                    state_d = ST_UPD_IR;
                end else begin
                    state_d = ST_PAU_IR;
                end
            end
            ST_PAU_IR: begin
                if (jtag_in.tms) begin
                    state_d = ST_EX2_IR;
                end else begin
                    state_d = ST_PAU_IR;
                end
            end
            ST_EX2_IR: begin
                if (jtag_in.tms) begin
                    state_d = ST_UPD_IR;
                end else begin
                    state_d = ST_SH_IR;
                end
            end
            ST_UPD_IR: begin
                if (jtag_in.tms) begin
                    state_d = ST_SEL_DR;
                end else begin
                    state_d = ST_IDLE;
                end
            end
            // a glitched code falls back to reset
            default: state_d = ST_RESET;
        endcase
    end

    // trst is a pin reset, asynchronous by nature of the port
    always_ff @(posedge tck or negedge trst_n) begin // R10 R11 R8
        if (!trst_n) begin
            state_q <= ST_RESET; // R12
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // instruction register
    // ------------------------------------------------------------
    logic [IR_W-1:0] ir_sh_q;
    logic [IR_W-1:0] ir_q;

    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            ir_sh_q <= IR_CAPTURE;
        end else if (state_q == ST_CAP_IR) begin
            ir_sh_q <= IR_CAPTURE; // R19
        end else if (state_q == ST_SH_IR) begin
            ir_sh_q <= {jtag_in.tdi, ir_sh_q[IR_W-1:1]}; // R2
        end
    end

    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            ir_q <= IR_RESET;
        end else if (state_q == ST_RESET) begin
            ir_q <= IR_RESET; // R20
        end else if (state_q == ST_UPD_IR) begin
            ir_q <= ir_sh_q; // R1
        end
    end

    // ------------------------------------------------------------
    // decode: unknown codes, including the absent optional ones, bypass
    // ------------------------------------------------------------
    logic sel_bsr;
    logic extest;

    assign extest = (ir_q == IR_EXTEST); // R23
    assign sel_bsr = extest || (ir_q == IR_SAMPLE); // R15 R16 R23

    // a flop copy for the core crossing, so it never sees a decode glitch
    logic extest_q;

    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            extest_q <= 1'b0;
        end else if (state_q == ST_RESET) begin
            extest_q <= 1'b0; // R20
        end else if (state_q == ST_UPD_IR) begin
            extest_q <= (ir_sh_q == IR_EXTEST); // R23
        end
    end

    // ------------------------------------------------------------
    // bypass register
    // ------------------------------------------------------------
    logic byp_q;

    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            byp_q <= BYP_RESET;
        end else if (state_q == ST_CAP_DR && !sel_bsr) begin
            byp_q <= BYP_RESET;
        end else if (state_q == ST_SH_DR && !sel_bsr) begin
            byp_q <= jtag_in.tdi; // R3 R4
        end
    end

    // ------------------------------------------------------------
    // boundary register: input cells low, output cells, enable cell top
    // ------------------------------------------------------------
    logic [LEN-1:0] bsr_q;
    logic [LEN-1:0] bsr_upd_q;
    logic [LEN-1:0] bsr_cap;

    // capture values per cell; input cells see pads, outputs see core
    genvar gi;
    generate
        for (gi = 0; gi < LEN; gi++) begin : g_cap
            if (gi < NIN) begin : g_in
                assign bsr_cap[gi] = pad_in[gi];
            end else if (gi < NIN + NOUT) begin : g_out
                assign bsr_cap[gi] = core_out[gi-NIN];
            end else begin : g_en
                assign bsr_cap[gi] = core_oe;
            end
        end
    endgenerate

    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            bsr_q <= '0;
        end else if (state_q == ST_CAP_DR && sel_bsr) begin
            bsr_q <= bsr_cap;
        end else if (state_q == ST_SH_DR && sel_bsr) begin
            bsr_q <= {bsr_q[LEN-2:0], jtag_in.tdi}; // R5 R6
        end
    end

    // latches load only at Update-DR, the enable latch also clears in Test-Logic-Reset, so shifting never reaches pads
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            bsr_upd_q <= '0;
        end else if (state_q == ST_RESET) begin
            bsr_upd_q[LEN-1] <= 1'b0; // R20
        end else if (state_q == ST_UPD_DR && sel_bsr) begin
            bsr_upd_q <= bsr_q; // R21
        end
    end

    // ------------------------------------------------------------
    // pads: transparent unless extest drives them from the latches
    // ------------------------------------------------------------
    // pins outside the chain never pass through this block
    assign core_in = pad_in; // R17 R18
    assign pad_out = extest ? bsr_upd_q[LEN-2:NIN] : core_out; // R17
    assign pad_oe = extest ? bsr_upd_q[LEN-1] : core_oe; // R20

    // ------------------------------------------------------------
    // serial output on falling tck
    // ------------------------------------------------------------
    logic tdo_d;
    logic shifting;

    assign shifting = (state_q == ST_SH_DR) || (state_q == ST_SH_IR);

    always_comb begin
        if (state_q == ST_SH_IR) begin
            tdo_d = ir_sh_q[0]; // R2
        end else if (sel_bsr) begin
            tdo_d = bsr_q[LEN-1]; // R7
        end else begin
            tdo_d = byp_q; // R4
        end
    end

    // half a cycle of hold for the tester's rising-edge sample
    always_ff @(negedge tck or negedge trst_n) begin // R9
        if (!trst_n) begin
            tdo_o <= 1'b0;
            tdo_oe <= 1'b0;
        end else begin
            // an undriven line reads low, never a stale bit
            tdo_o <= shifting ? tdo_d : 1'b0;
            tdo_oe <= shifting; // R24
        end
    end

    // ------------------------------------------------------------
    // core clock side: extest level crossed by two flip-flops
    // ------------------------------------------------------------
    logic tm_meta_q;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tm_meta_q <= 1'b0;
            test_mode_q <= 1'b0;
        end else begin
            tm_meta_q <= extest_q;
            test_mode_q <= tm_meta_q;
        end
    end

endmodule

/* File: bstap_chk.sv */
// assertions on the boundary-scan port pins
module bstap_chk
    import bstap_pkg::*;
#(
    parameter int LEN = BSR_LEN,
    parameter int NIN = BSR_IN_CELLS
) (
    input wire logic tck,
    input wire logic trst_n,
    input wire bstap_pins_s jtag_in,
    input wire logic tdo_o,
    input wire logic tdo_oe,
    input wire logic [NIN-1:0] pad_in,
    input wire logic [NIN-1:0] core_in,
    input wire logic [LEN-NIN-2:0] core_out,
    input wire logic core_oe,
    input wire logic [LEN-NIN-2:0] pad_out,
    input wire logic pad_oe
);
    logic [1:0] rise_q;
    // pin values at the last rising tck; they must hold until falling tck
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            rise_q <= 2'b00;
        end else begin
            rise_q <= {tdo_o, tdo_oe};
        end
    end
    default clocking @(posedge tck); endclocking
    default disable iff (!trst_n);
    // ----
    // assertions
    // ----
    property p_tdo_edge; @(negedge tck) tdo_o == rise_q[1]; endproperty
    a_tdo_edge: assert property (p_tdo_edge) else $error("tdo moved");
    property p_oe_edge; @(negedge tck) tdo_oe == rise_q[0]; endproperty
    a_oe_edge: assert property (p_oe_edge) else $error("oe moved");
    property p_quiet; !tdo_oe |-> !tdo_o; endproperty
    a_quiet: assert property (p_quiet) else $error("tdo not idle");
    property p_five; jtag_in.tms [*5] |=> !tdo_oe; endproperty
    a_five: assert property (p_five) else $error("no reset");
    property p_tlr_pads; jtag_in.tms [*6] |=> pad_oe == core_oe; endproperty
    a_tlr_pads: assert property (p_tlr_pads) else $error("pad oe");
    property p_stay; tdo_oe && !jtag_in.tms |=> tdo_oe; endproperty
    a_stay: assert property (p_stay) else $error("left shift");
    property p_exit; tdo_oe && jtag_in.tms |=> !tdo_oe; endproperty
    a_exit: assert property (p_exit) else $error("no exit");
    property p_transp; core_in == pad_in; endproperty
    a_transp: assert property (p_transp) else $error("pads cut");
    cover property (tdo_oe && jtag_in.tms);
    cover property (jtag_in.tms [*5]);
    cover property (pad_out != core_out);
endmodule
bind bstap_top bstap_chk #(.LEN(LEN), .NIN(NIN)) i_chk (.*);

/* File: bstap_tester.sv */
// tester model driving the test port pins
module bstap_tester
    import bstap_pkg::*;
(
    output logic tck,
    output logic trst_n,
    output bstap_pins_s jtag_in,
    input wire logic tdo_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic bit_q;
    initial {tck, trst_n, jtag_in} = 4'h0;
    // tck rests low outside frames; tdi toggles when unused
    task automatic step(input logic tms, input logic tdi);
        jtag_in = {tms, tdi};
        #3 bit_q = tdo_o;
        tck = 1'b1;
        #3 tck = 1'b0;
    endtask
    task automatic hard_reset();
        #10 trst_n = 1'b1;
    endtask
    task automatic tms_reset();
        repeat (6) step(1'b1, ~jtag_in.tdi);
        step(1'b0, ~jtag_in.tdi);
    endtask
    task automatic scan(input logic ir, input int n,
                        input logic [296:0] din, output logic [296:0] dout);
        dout = '0;
        step(1'b1, 1'b0);
        if (ir) step(1'b1, 1'b1);
        step(1'b0, 1'b0);
        step(1'b0, 1'b1);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i]);
            dout[i] = bit_q;
        end
        step(1'b1, 1'b0);
        step(1'b0, 1'b1);
    endtask
endmodule

/* File: tb_boundary_scan_tap.sv */
// self-checking bench of the boundary-scan port
module tb_boundary_scan_tap
    import bstap_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int N = BSR_IN_CELLS;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic tck, trst_n, tdo_o, tdo_oe, core_oe = 1'b0, pad_oe, test_mode_q;
    bstap_pins_s jtag_in;
    logic [N-1:0] pad_in = '0, core_in, core_out = '0, pad_out;
    logic [296:0] dout, v, din;
    int err_count = 0;
    int tests_run = 0;
    int cyc = 0;
    always #25 clock = ~clock;
    bstap_tester i_tst (.tck, .trst_n, .jtag_in, .tdo_o);
    bstap_top i_dut (.clock, .rst_n, .tck, .trst_n, .jtag_in, .tdo_o,
        .tdo_oe, .pad_in, .core_in, .core_out, .core_oe, .pad_out, .pad_oe,
        .test_mode_q);
    function automatic logic [296:0] rnd();
        for (int i = 0; i < 297; i++) rnd[i] = 1'($urandom);
    endfunction
    // reference register: the queue front is the bit that leaves on tdo
    bit mdl_q[$];
    task automatic mdl_load(input logic [296:0] c, input int len,
                            input bit msb_out);
        mdl_q.delete();
        for (int i = 0; i < len; i++) begin
            mdl_q.push_back(msb_out ? c[len - 1 - i] : c[i]);
        end
    endtask
    function automatic logic [296:0] mdl_shift(input logic [296:0] d,
                                               input int n);
        mdl_shift = '0;
        for (int i = 0; i < n; i++) begin
            mdl_shift[i] = mdl_q.pop_front();
            mdl_q.push_back(d[i]);
        end
    endfunction
    function automatic logic [296:0] mdl_word();
        for (int j = 0; j < 297; j++) mdl_word[296 - j] = mdl_q[j];
    endfunction
    task automatic check(input string s, input logic [296:0] e, g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // whole run needs some 60 clocks, about 400 tck cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_count++;
            complete_run();
        end
    end
    initial begin
        void'($urandom(8457));
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        i_tst.hard_reset();
        i_tst.tms_reset();
        for (int k = 0; k < 3; k++) begin
            if (k > 0) begin
                v = 297'(k > 1 ? 4'hf : 4'($urandom_range(14, 2)));
                mdl_load(297'(4'h1), IR_W, 1'b0);
                i_tst.scan(1'b1, 4, v, dout);
                check("ir capture", mdl_shift(v, IR_W), dout);
            end
            din = rnd();
            mdl_load('0, 1, 1'b0);
            i_tst.scan(1'b0, 8, din, dout);
            check("bypass", mdl_shift(din, 8), dout);
        end
        $display("done bypass");
        v = rnd();
        @(posedge clock);
        pad_in <= v[N-1:0];
        core_out <= v[295:N];
        core_oe <= v[296];
        i_tst.scan(1'b1, 4, 297'(4'h1), dout);
        din = rnd();
        mdl_load(v, BSR_LEN, 1'b1);
        i_tst.scan(1'b0, 297, din, dout);
        check("bsr out", mdl_shift(din, BSR_LEN), dout);
        check("core in", 297'(v[N-1:0]), 297'(core_in));
        $display("done sample");
        i_tst.scan(1'b1, 4, 297'(4'h0), dout);
        v = mdl_word();
        repeat (4) @(posedge clock);
        check("extest", 297'({v[296:N], 1'b1}),
            297'({pad_oe, pad_out, test_mode_q}));
        $display("done extest");
        i_tst.tms_reset();
        repeat (4) @(posedge clock);
        check("release", 297'({core_oe, core_out, 1'b0}),
            297'({pad_oe, pad_out, test_mode_q}));
        $display("done reset");
        complete_run();
    end
endmodule
